// *** fpp_pkg.sv ***
// Shared constants, field layouts and types for the pipeline mode control block.
package fpp_pkg;

  // Data path widths.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 4;
  localparam int unsigned EXC_W  = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CNT_W  = 4;
  localparam int unsigned RFA_W  = 3;

  // Transaction addresses on the register port.
  localparam logic [3:0] ADDR_WR_R      = 4'h0;
  localparam logic [3:0] ADDR_WR_S      = 4'h1;
  localparam logic [3:0] ADDR_WR_RS     = 4'h2;
  localparam logic [3:0] ADDR_WR_INSTR  = 4'h3;
  localparam logic [3:0] ADDR_RD_RESULT = 4'h4;
  localparam logic [3:0] ADDR_RD_FLAGS  = 4'h5;
  localparam logic [3:0] ADDR_RD_STATUS = 4'h6;
  localparam logic [3:0] ADDR_WR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_WR_MODE   = 4'h8;
  localparam logic [3:0] ADDR_RD_MODE   = 4'h9;
  localparam logic [3:0] ADDR_SAVE      = 4'hA;

  // Mode register fields.
  localparam int unsigned MODE_PL_BIT   = 0;
  localparam int unsigned MODE_HE_BIT   = 1;
  localparam int unsigned MODE_EX_BIT   = 2;
  localparam int unsigned MODE_CNT_LSB  = 4;
  localparam int unsigned MODE_MASK_LSB = 8;
  localparam logic [31:0] MODE_RESET    = 32'h0000_0030;

  // Status register fields.
  localparam int unsigned STAT_ES_BIT  = 8;
  localparam logic [8:0]  STATUS_RESET = 9'h000;

  // Instruction word fields seen by the sequencer.
  localparam int unsigned INSTR_MAC_BIT = 31;
  localparam int unsigned INSTR_RF_BIT  = 30;
  localparam int unsigned INSTR_RFA_LSB = 27;

  // Least legal stage cycle count.
  localparam logic [3:0] CNT_MIN = 4'h3;

  // One pipeline register: data plus the valid tag that travels with it.
  typedef struct packed {
    logic              valid;
    logic              mac;
    logic              rf_wr;
    logic [RFA_W-1:0]  rf_addr;
    logic [DATA_W-1:0] result;
    logic [FLAG_W-1:0] flags;
    logic [EXC_W-1:0]  exc;
  } fpp_entry_type;

  localparam fpp_entry_type ENTRY_EMPTY = '0;

  // Answer sequencer states.
  typedef enum logic [1:0] {
    TR_IDLE  = 2'b01,
    TR_STALL = 2'b10
  } fpp_tr_state_type;

endpackage : fpp_pkg

// *** fpp_timer_if.sv ***
// Carrier between the sequencer and its stage timer.
`timescale 1ns/1ps
interface fpp_timer_if;
  logic       load;
  logic [3:0] count;
  logic       busy;
  logic       done;

  modport ctrl  (output load, output count, input busy, input done);
  modport timer (input load, input count, output busy, output done);
endinterface : fpp_timer_if

// *** fpp_stage_timer.sv ***
// Stage occupancy timer: counts the cycles one operation spends in a stage.
`timescale 1ns/1ps
module fpp_stage_timer (
  input wire logic  clk,
  input wire logic  reset_n,
  fpp_timer_if.timer tif
);

  logic [3:0] remain_reg;
  logic       done_reg;

  // Reload on every start; a count below one would never show busy, so it is forced to one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remain_reg <= 4'h0;
    end else if (tif.load) begin
      remain_reg <= (tif.count == 4'h0) ? 4'h1 : tif.count; // RULE_12
    end else if (remain_reg != 4'h0) begin
      remain_reg <= remain_reg - 4'h1;
    end
  end

  // One-cycle pulse in the cycle after the last counted cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= !tif.load && (remain_reg == 4'h1);
    end
  end

  assign tif.busy = (remain_reg != 4'h0);
  assign tif.done = done_reg;

endmodule : fpp_stage_timer

// *** fpp_pipe_ctrl.sv ***
// Pipeline mode sequencer: starts, holding registers, pipeline advance, errors, invalidation.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
//
// Function
// RULE_01: Pipeline select bit high enables pipeline operation, else flow-through.
// RULE_02: Multiply-accumulate uses three stages, every other operation two; once a multiply-accumulate has passed, every later operation uses three.
// RULE_03: Host programs stage cycle count between 3 and 15.
// RULE_04: Exception output low on unmasked exception when its enable bit is set.
// RULE_05: Pipeline advances only when a new operation starts.
// RULE_06: Two-stage result reaches output registers after two further starts.
// RULE_07: Host raises the start flag only on the final specification write.
// RULE_08: Start-flagged operand or instruction write starts the operation next cycle.
// RULE_09: At start copy only holding registers written for this operation.
// RULE_10: Start-carrying word bypasses holding registers into its working register.
// RULE_11: Start moves last stage to result, flags, status, register file. Code skips the register file write for a result with an unmasked exception.
// RULE_12: Each operation occupies a stage for the stage cycle count.
// RULE_13: Start during first stage is held and begins when that stage ends.
// RULE_14: Halt-on-error with unmasked exception keeps new operation pending until cleared.
// RULE_15: Result, flag and status registers readable any time after a start.
// RULE_16: Reads stall while a fully specified operation waits, then return new values.
// RULE_17: Save-state refused in pipeline mode, served in flow-through mode.
// RULE_18: Unmasked exception gives transaction error on result, flag, status reads.
// RULE_19: Start flag on such a read suppresses the transaction error.
// RULE_20: Halt-on-error drops availability when faulting result reaches output registers.
// RULE_21: While halted, operand and instruction writes error next cycle, unchanged.
// RULE_22: Halt releases only when summary and responsible exception bits are cleared.
// RULE_23: Invalid results never update status or register file.
// RULE_24: Switching into pipeline mode invalidates all pipeline contents.
// RULE_25: Multiply-accumulate after another operation invalidates the spurious result.
// RULE_26: Status write with start flag invalidates pipeline; no effect in flow-through.
// RULE_27: Every pipeline register carries a valid tag cleared by reset.
module fpp_pipe_ctrl (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [fpp_pkg::ADDR_W-1:0] addr,
  input  wire logic [fpp_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_strobe,
  input  wire logic                       rd_strobe,
  input  wire logic                       op_start_flag,
  output logic      [fpp_pkg::DATA_W-1:0] rdata,
  output logic                            trans_ready,
  output logic                            transaction_error,
  output logic                            accel_available,
  output logic                            exception_out_n,
  input  wire logic [fpp_pkg::DATA_W-1:0] alu_result,
  input  wire logic [fpp_pkg::FLAG_W-1:0] alu_flags,
  input  wire logic [fpp_pkg::EXC_W-1:0]  alu_exc,
  output logic      [fpp_pkg::DATA_W-1:0] work_r,
  output logic      [fpp_pkg::DATA_W-1:0] work_s,
  output logic      [fpp_pkg::DATA_W-1:0] work_instr,
  output logic                            stage_advance,
  output logic                            rf_we,
  output logic      [fpp_pkg::RFA_W-1:0]  rf_waddr,
  output logic      [fpp_pkg::DATA_W-1:0] rf_wdata
);

  fpp_timer_if tif ();

  fpp_stage_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  logic [31:0]                mode_reg;
  logic [8:0]                 status_reg;
  logic [8:0]                 status_next;
  logic [fpp_pkg::DATA_W-1:0] r_hold_reg;
  logic [fpp_pkg::DATA_W-1:0] s_hold_reg;
  logic [fpp_pkg::DATA_W-1:0] i_hold_reg;
  logic                       r_held_reg;
  logic                       s_held_reg;
  logic                       i_held_reg;
  logic                       start_pending_reg;
  logic                       work_valid_reg;
  logic                       flow_busy_reg;
  logic                       deep_reg;
  fpp_pkg::fpp_entry_type     p1_reg;
  fpp_pkg::fpp_entry_type     p2_reg;
  fpp_pkg::fpp_entry_type     last_entry;
  fpp_pkg::fpp_entry_type     p2_next;
  fpp_pkg::fpp_entry_type     new_entry;
  logic                       deep_next;
  logic [fpp_pkg::DATA_W-1:0] result_reg;
  logic [fpp_pkg::FLAG_W-1:0] flags_reg;
  fpp_pkg::fpp_tr_state_type  tr_state_reg;
  logic [fpp_pkg::ADDR_W-1:0] stall_addr_reg;
  logic                       stall_flag_reg;

  // Decoded mode and request terms.
  logic                       pipe_mode;
  logic                       halt_mode;
  logic [fpp_pkg::EXC_W-1:0]  exc_mask;
  logic                       unmasked;
  logic                       halted;
  logic                       is_opwrite;
  logic                       has_r;
  logic                       has_s;
  logic                       has_i;
  logic                       blocked;
  logic                       start_now;
  logic                       pend_go;
  logic                       advance;
  logic                       invalidate;
  logic                       flow_finish;
  logic                       new_fault;

  assign pipe_mode  = mode_reg[fpp_pkg::MODE_PL_BIT]; // RULE_01
  assign halt_mode  = mode_reg[fpp_pkg::MODE_HE_BIT];
  assign exc_mask   = mode_reg[fpp_pkg::MODE_MASK_LSB +: fpp_pkg::EXC_W];
  assign unmasked   = |(status_reg[fpp_pkg::EXC_W-1:0] & ~exc_mask);
  assign halted     = !accel_available;
  assign has_r      = (addr == fpp_pkg::ADDR_WR_R) || (addr == fpp_pkg::ADDR_WR_RS);
  assign has_s      = (addr == fpp_pkg::ADDR_WR_S) || (addr == fpp_pkg::ADDR_WR_RS);
  assign has_i      = (addr == fpp_pkg::ADDR_WR_INSTR);
  assign is_opwrite = wr_strobe && (has_r || has_s || has_i);

  // A start waits out the first stage and, in halt mode, any unmasked exception.
  assign blocked    = tif.busy || (halt_mode && unmasked); // RULE_13 RULE_14
  assign start_now  = is_opwrite && op_start_flag && !halted && !blocked; // RULE_08
  assign pend_go    = start_pending_reg && !blocked; // RULE_13 RULE_14
  assign advance    = start_now || pend_go; // RULE_05

  // Manual invalidation and the flow-through to pipeline switch both flush the pipe.
  assign invalidate = (wr_strobe && (addr == fpp_pkg::ADDR_WR_STATUS) && op_start_flag
                       && pipe_mode) // RULE_26
                    || (wr_strobe && (addr == fpp_pkg::ADDR_WR_MODE) && !pipe_mode
                        && wdata[fpp_pkg::MODE_PL_BIT]); // RULE_24
  assign flow_finish = !pipe_mode && flow_busy_reg && tif.done;

  assign tif.load  = advance;
  assign tif.count = mode_reg[fpp_pkg::MODE_CNT_LSB +: fpp_pkg::CNT_W]; // RULE_12 RULE_03

  // Stage-one output of the operation now in the working registers.
  always_comb begin
    new_entry         = fpp_pkg::ENTRY_EMPTY;
    new_entry.valid   = work_valid_reg && pipe_mode;
    new_entry.mac     = work_instr[fpp_pkg::INSTR_MAC_BIT];
    new_entry.rf_wr   = work_instr[fpp_pkg::INSTR_RF_BIT];
    new_entry.rf_addr = work_instr[fpp_pkg::INSTR_RFA_LSB +: fpp_pkg::RFA_W];
    new_entry.result  = alu_result;
    new_entry.flags   = alu_flags;
    new_entry.exc     = alu_exc;
  end

  // Stage length selection: a multiply-accumulate in stage one opens a third stage.
  // Once open it stays open, so no later result is lost behind it.
  always_comb begin
    last_entry = p1_reg;
    p2_next    = p2_reg;
    deep_next  = deep_reg;
    if (deep_reg) begin
      last_entry = p2_reg; // RULE_02
      p2_next    = p1_reg;
    end else if (p1_reg.mac) begin
      last_entry = fpp_pkg::ENTRY_EMPTY; // RULE_25
      p2_next    = p1_reg; // RULE_02
      deep_next  = 1'b1;
    end
  end

  // A fault is a valid result bringing an unmasked exception to the output registers.
  assign new_fault = pipe_mode ? (advance && last_entry.valid
                                  && |(last_entry.exc & ~exc_mask))
                               : (flow_finish && |(alu_exc & ~exc_mask));

  // Mode register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= fpp_pkg::MODE_RESET;
    end else if (wr_strobe && (addr == fpp_pkg::ADDR_WR_MODE)) begin
      mode_reg <= wdata;
    end
  end

  // Status: a plain write replaces it, a result sets bits; the set wins a same-cycle clear.
  always_comb begin
    status_next = status_reg;
    if (wr_strobe && (addr == fpp_pkg::ADDR_WR_STATUS) && !op_start_flag) begin
      status_next = wdata[8:0]; // RULE_22
    end
    if (pipe_mode && advance && last_entry.valid) begin
      status_next[fpp_pkg::EXC_W-1:0] = status_next[fpp_pkg::EXC_W-1:0]
                                        | last_entry.exc; // RULE_11 RULE_23
    end else if (flow_finish) begin
      status_next[fpp_pkg::EXC_W-1:0] = status_next[fpp_pkg::EXC_W-1:0] | alu_exc;
    end
    if (new_fault) begin
      status_next[fpp_pkg::STAT_ES_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= fpp_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Holding registers take specification writes that cannot go straight to work.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_hold_reg <= 32'h0000_0000;
      s_hold_reg <= 32'h0000_0000;
      i_hold_reg <= 32'h0000_0000;
      r_held_reg <= 1'b0;
      s_held_reg <= 1'b0;
      i_held_reg <= 1'b0;
    end else if (is_opwrite && !halted && !start_now) begin
      if (has_r) begin
        r_hold_reg <= wdata;
        r_held_reg <= 1'b1;
      end
      if (has_s) begin
        s_hold_reg <= wdata;
        s_held_reg <= 1'b1;
      end
      if (has_i) begin
        i_hold_reg <= wdata;
        i_held_reg <= 1'b1;
      end
    end else if (advance) begin
      r_held_reg <= 1'b0; // RULE_09
      s_held_reg <= 1'b0;
      i_held_reg <= 1'b0;
    end
  end

  // A start that cannot run now stays pending; a halted device takes no new start.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_pending_reg <= 1'b0;
    end else if (pend_go) begin
      start_pending_reg <= 1'b0;
    end else if (is_opwrite && op_start_flag && !halted && blocked) begin
      start_pending_reg <= 1'b1; // RULE_13
    end
  end

  // Working registers: held words are copied, the start-carrying word goes direct.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      work_r     <= 32'h0000_0000;
      work_s     <= 32'h0000_0000;
      work_instr <= 32'h0000_0000;
    end else if (advance) begin
      if (start_now && has_r) begin
        work_r <= wdata; // RULE_10
      end else if (r_held_reg) begin
        work_r <= r_hold_reg; // RULE_09
      end
      if (start_now && has_s) begin
        work_s <= wdata; // RULE_10
      end else if (s_held_reg) begin
        work_s <= s_hold_reg; // RULE_09
      end
      if (start_now && has_i) begin
        work_instr <= wdata; // RULE_10
      end else if (i_held_reg) begin
        work_instr <= i_hold_reg; // RULE_09
      end
    end
  end

  // Pipeline registers move only on a start; each carries its valid tag.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p1_reg         <= fpp_pkg::ENTRY_EMPTY; // RULE_27
      p2_reg         <= fpp_pkg::ENTRY_EMPTY; // RULE_27
      deep_reg       <= 1'b0;
      work_valid_reg <= 1'b0;
    end else if (invalidate) begin
      p1_reg.valid   <= 1'b0; // RULE_24 RULE_26
      p2_reg.valid   <= 1'b0;
      work_valid_reg <= 1'b0;
    end else if (advance && pipe_mode) begin
      p1_reg         <= new_entry; // RULE_05 RULE_06 RULE_11
      p2_reg         <= p2_next;
      deep_reg       <= deep_next;
      work_valid_reg <= 1'b1;
    end
  end

  // Result and flag registers take the last stage output at each start in pipeline mode, the ALU output when a flow-through operation ends.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= 32'h0000_0000;
      flags_reg  <= 4'h0;
    end else if (pipe_mode && advance) begin
      result_reg <= last_entry.result; // RULE_11 RULE_06
      flags_reg  <= last_entry.flags;
    end else if (flow_finish) begin
      result_reg <= alu_result;
      flags_reg  <= alu_flags;
    end
  end

  // Register file write leaves only for a valid result that asks for it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_we         <= 1'b0;
      rf_waddr      <= 3'h0;
      rf_wdata      <= 32'h0000_0000;
      stage_advance <= 1'b0;
    end else begin
      rf_we         <= pipe_mode && advance && last_entry.valid
                       && last_entry.rf_wr && !new_fault; // RULE_11 RULE_23
      rf_waddr      <= last_entry.rf_addr;
      rf_wdata      <= last_entry.result;
      stage_advance <= advance && pipe_mode;
    end
  end

  // Flow-through operation runs one timer span and then delivers its result.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flow_busy_reg <= 1'b0;
    end else if (advance && !pipe_mode) begin
      flow_busy_reg <= 1'b1;
    end else if (flow_finish) begin
      flow_busy_reg <= 1'b0;
    end
  end

  // Availability drops with the fault in halt mode and returns once software clears the bits.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accel_available <= 1'b1;
    end else if (halt_mode && new_fault) begin
      accel_available <= 1'b0; // RULE_20
    end else if (!status_next[fpp_pkg::STAT_ES_BIT]
                 && !(|(status_next[fpp_pkg::EXC_W-1:0] & ~exc_mask))) begin
      accel_available <= 1'b1; // RULE_22
    end
  end

  // Exception pin follows the unmasked exception, gated only by its own enable bit.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exception_out_n <= 1'b1;
    end else begin
      exception_out_n <= !(mode_reg[fpp_pkg::MODE_EX_BIT]
                           && |(status_next[fpp_pkg::EXC_W-1:0] & ~exc_mask)); // RULE_04
    end
  end

  // Read data for one address; save-state shows the R working register.
  function automatic logic [fpp_pkg::DATA_W-1:0] read_mux(input logic [3:0] a);
    logic [fpp_pkg::DATA_W-1:0] d;
    d = 32'h0000_0000;
    case (a)
      fpp_pkg::ADDR_RD_RESULT: d = result_reg; // RULE_15
      fpp_pkg::ADDR_RD_FLAGS:  d = {28'h000_0000, flags_reg};
      fpp_pkg::ADDR_RD_STATUS: d = {23'h00_0000, status_reg};
      fpp_pkg::ADDR_RD_MODE:   d = mode_reg;
      fpp_pkg::ADDR_SAVE:      d = work_r;
      default:                 d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_mux

  // Reads of result, flags or status that may report an exception.
  function automatic logic is_out_read(input logic [3:0] a);
    return (a == fpp_pkg::ADDR_RD_RESULT) || (a == fpp_pkg::ADDR_RD_FLAGS)
           || (a == fpp_pkg::ADDR_RD_STATUS);
  endfunction : is_out_read

  // Answer sequencer. Result, flag and status reads wait while a fully specified operation is pending, so
  // the answer is given only after that operation starts; a halt can prolong the wait.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tr_state_reg      <= fpp_pkg::TR_IDLE;
      stall_addr_reg    <= 4'h0;
      stall_flag_reg    <= 1'b0;
      rdata             <= 32'h0000_0000;
      trans_ready       <= 1'b0;
      transaction_error <= 1'b0;
    end else begin
      trans_ready       <= 1'b0;
      transaction_error <= 1'b0;
      case (tr_state_reg)
        fpp_pkg::TR_IDLE: begin
          if (wr_strobe) begin
            trans_ready       <= 1'b1;
            transaction_error <= is_opwrite && halted; // RULE_21
          end else if (rd_strobe && start_pending_reg
                       && is_out_read(addr)) begin
            tr_state_reg   <= fpp_pkg::TR_STALL; // RULE_16
            stall_addr_reg <= addr;
            stall_flag_reg <= op_start_flag;
          end else if (rd_strobe) begin
            trans_ready       <= 1'b1;
            rdata             <= read_mux(addr);
            transaction_error <= (is_out_read(addr) && unmasked
                                  && !op_start_flag) // RULE_18 RULE_19
                               || ((addr == fpp_pkg::ADDR_SAVE) && pipe_mode); // RULE_17
          end
        end
        fpp_pkg::TR_STALL: begin
          if (!start_pending_reg) begin
            tr_state_reg      <= fpp_pkg::TR_IDLE;
            trans_ready       <= 1'b1;
            rdata             <= read_mux(stall_addr_reg); // RULE_16
            transaction_error <= unmasked && !stall_flag_reg; // RULE_18 RULE_19
          end
        end
        default: begin
          tr_state_reg <= fpp_pkg::TR_IDLE;
        end
      endcase
    end
  end

endmodule : fpp_pipe_ctrl

// *** fpp_alu_model.sv ***
// Behavioural arithmetic unit standing beside the sequencer's working registers.
`timescale 1ns/1ps
module fpp_alu_model (
  input  wire logic [31:0] work_r,
  input  wire logic [31:0] work_s,
  input  wire logic [31:0] work_instr,
  output logic      [31:0] alu_result,
  output logic      [3:0]  alu_flags,
  output logic      [7:0]  alu_exc
);
  // A sum lets each result name its operands; the low instruction byte injects exceptions.
  assign alu_result = work_r + work_s;
  assign alu_flags  = 4'h0;
  assign alu_exc    = work_instr[7:0];
endmodule : fpp_alu_model

// *** fpp_pipe_ctrl_chk.sv ***
// Port-level assertions for the pipeline mode sequencer.
`timescale 1ns/1ps
module fpp_pipe_ctrl_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [3:0]  addr,
  input wire logic        wr_strobe,
  input wire logic        rd_strobe,
  input wire logic        op_start_flag,
  input wire logic [31:0] rdata,
  input wire logic        trans_ready,
  input wire logic        transaction_error,
  input wire logic        accel_available,
  input wire logic        stage_advance
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_write_answer: assert property (wr_strobe |=> trans_ready)
    else $error("write not answered next cycle");
  a_error_paired: assert property (transaction_error |-> trans_ready)
    else $error("error without answer");
  a_halt_write_err: assert property (wr_strobe && addr < 4'h4 && !accel_available
    |=> transaction_error)
    else $error("write while halted not refused");
  a_awake_write_ok: assert property (wr_strobe && addr < 4'h4 && accel_available
    |=> !transaction_error)
    else $error("write refused while available");
  a_start_read_quiet: assert property (rd_strobe && op_start_flag
    && addr == fpp_pkg::ADDR_RD_STATUS |=> !transaction_error)
    else $error("error not suppressed");
  a_stage_gap: assert property (stage_advance |=> (!stage_advance)[*2])
    else $error("stage advanced before count elapsed");
  a_rdata_hold: assert property (!$stable(rdata) |-> trans_ready)
    else $error("read data changed without answer");
  a_halt_release: assert property ($rose(accel_available)
    |-> $past(wr_strobe) || $past(wr_strobe, 2))
    else $error("halt left without a clearing write");
endmodule : fpp_pipe_ctrl_chk
bind fpp_pipe_ctrl fpp_pipe_ctrl_chk u_chk (.clk(clk), .reset_n(reset_n), .addr(addr),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .op_start_flag(op_start_flag),
  .rdata(rdata), .trans_ready(trans_ready), .transaction_error(transaction_error),
  .accel_available(accel_available), .stage_advance(stage_advance));

// *** tb_fpp_pipe_ctrl.sv ***
// Self-checking bench for the pipeline mode sequencer.
`timescale 1ns/1ps
module tb_fpp_pipe_ctrl;
  logic clk = 1'b0, reset_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, op_start_flag = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, work_r, work_s, work_instr, alu_result, rf_wdata;
  logic [31:0] got;
  logic [3:0]  alu_flags;
  logic [7:0]  alu_exc;
  logic [2:0]  rf_waddr;
  logic        trans_ready, transaction_error, accel_available, exception_out_n;
  logic        stage_advance, rf_we, err;
  int          error_cnt = 0, cmp_count = 0, adv_n = 0;

  // The clock toggles every 12.5 ns, a period of 25 ns.
  always #12.5 clk = ~clk;

  fpp_pipe_ctrl dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .op_start_flag(op_start_flag),
    .rdata(rdata), .trans_ready(trans_ready), .transaction_error(transaction_error),
    .accel_available(accel_available), .exception_out_n(exception_out_n),
    .alu_result(alu_result), .alu_flags(alu_flags), .alu_exc(alu_exc), .work_r(work_r),
    .work_s(work_s), .work_instr(work_instr), .stage_advance(stage_advance),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata));
  fpp_alu_model alu (.work_r(work_r), .work_s(work_s), .work_instr(work_instr),
    .alu_result(alu_result), .alu_flags(alu_flags), .alu_exc(alu_exc));

  // Pipeline advances are counted so that a drifting pipe shows up as extra pulses.
  always @(posedge clk) if (stage_advance === 1'b1) adv_n <= adv_n + 1;

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One request; a stalled read is waited for under a bound, never forever.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, input logic st);
    int n;
    n = 0;
    @(posedge clk);
    wr_strobe <= w;
    rd_strobe <= !w;
    addr <= a;
    wdata <= d;
    op_start_flag <= st;
    @(posedge clk);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    op_start_flag <= 1'b0;
    #1;
    while (trans_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) chk("answer", 32'h0, 32'h1);
    got = rdata;
    err = transaction_error;
  endtask : xfer

  // Bounded wait for a level, then its comparison.
  task automatic wait_lvl(input string nm, ref logic sig, input logic exp);
    for (int n = 0; n < 20 && sig !== exp; n++) @(posedge clk);
    chk(nm, sig, exp);
  endtask : wait_lvl

  // The start flag rides only on the last write of each operation.
  task automatic op(input logic [31:0] r, input logic [31:0] s);
    xfer(1'b1, fpp_pkg::ADDR_WR_R, r, 1'b0);
    xfer(1'b1, fpp_pkg::ADDR_WR_S, s, 1'b1);
  endtask : op

  initial begin
    #(25ns * 6000);
    error_cnt++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("avail", accel_available, 1'b1);
    chk("work_r", work_r, 32'h0);
    xfer(1'b1, fpp_pkg::ADDR_WR_MODE, 32'h0000_0035, 1'b0);
    op(32'h1, 32'h2);
    op(32'hA, 32'h14);
    op(32'h64, 32'hC8);
    xfer(1'b0, fpp_pkg::ADDR_RD_RESULT, 32'h0, 1'b0);
    chk("result", got, 32'h3);
    chk("advances", adv_n, 32'h3);
    repeat (20) @(posedge clk);
    chk("advances", adv_n, 32'h3);
    chk("work_s", work_s, 32'hC8);
    xfer(1'b1, fpp_pkg::ADDR_WR_S, 32'h5, 1'b1);
    xfer(1'b0, fpp_pkg::ADDR_RD_RESULT, 32'h0, 1'b0);
    chk("result", got, 32'h1E);
    chk("work_r", work_r, 32'h64);
    xfer(1'b0, fpp_pkg::ADDR_SAVE, 32'h0, 1'b0);
    chk("save", err, 1'b1);
    xfer(1'b0, 4'hF, 32'h0, 1'b0);
    chk("unmapped", got, 32'h0);
    xfer(1'b1, fpp_pkg::ADDR_WR_MODE, 32'h0000_0037, 1'b0);
    xfer(1'b0, fpp_pkg::ADDR_RD_MODE, 32'h0, 1'b0);
    chk("mode", got, 32'h0000_0037);
    xfer(1'b1, fpp_pkg::ADDR_WR_INSTR, 32'h1, 1'b0);
    op(32'h1, 32'h1);
    xfer(1'b1, fpp_pkg::ADDR_WR_INSTR, 32'h0, 1'b0);
    xfer(1'b1, fpp_pkg::ADDR_WR_S, 32'h2, 1'b1);
    chk("avail", accel_available, 1'b1);
    xfer(1'b1, fpp_pkg::ADDR_WR_S, 32'h3, 1'b1);
    wait_lvl("avail", accel_available, 1'b0);
    chk("exc_pin", exception_out_n, 1'b0);
    xfer(1'b0, fpp_pkg::ADDR_RD_STATUS, 32'h0, 1'b1);
    chk("quiet", err, 1'b0);
    chk("status", got[7:0], 8'h01);
    xfer(1'b0, fpp_pkg::ADDR_RD_STATUS, 32'h0, 1'b0);
    chk("read_err", err, 1'b1);
    xfer(1'b1, fpp_pkg::ADDR_WR_R, 32'h4D, 1'b0);
    chk("halt_err", err, 1'b1);
    chk("work_r", work_r, 32'h1);
    xfer(1'b1, fpp_pkg::ADDR_WR_STATUS, 32'h0, 1'b0);
    wait_lvl("avail", accel_available, 1'b1);
    wait_lvl("exc_pin", exception_out_n, 1'b1);
    end_of_test();
  end
endmodule : tb_fpp_pipe_ctrl
